// ---- hdl/wdd_pkg.sv ----
// Constants, register map and carrier types for the watchdog and discharge timer
// Behaviour
// - Watchdog expires after more than two seconds without a valid command.
// - Every watchdog expiry resets config A bytes 0-3 and config B GPIO bits.
// - With discharge timer idle, expiry also resets A4-5, switch control, rest of B.
// - Watchdog expiry releases the open-drain watchdog pin; pull-up drives it high.
// - Watchdog always enabled; restarts on each valid command with good check code.
// - While discharge timer runs, watchdog expiry leaves discharge switches on.
// - Discharge timer needs enable pin high; code 0 disables, 1-F give 0.5-120 minutes.
// - Discharge expiry resets A4-5, switch control and remaining config B bits.
// - Timeout code reads back as remaining-time bucket, 0 when idle or expired.
// - Discharge timer restarts only on a valid config A write, not other commands.
// - Expiry during config A write still stores the new data when write completes.
// - Die over-temperature resets config and switch groups, discharge switches off.
// - Thermal shutdown sets the thermal shutdown flag in status B.
// - Clear-status command sets the thermal flag without resetting any config group.
// - Reading status B clears the thermal shutdown flag.
// - Status B holds a 4-bit version field, all bits returned on reads.
package wdd_pkg;

   // Clock and time base
   localparam int CLK_MHZ        = 200;
   localparam int TICK_MS        = 100;
   localparam int TICK_CYCLES    = TICK_MS * 1000 * CLK_MHZ;
   localparam int WDOG_MS        = 2000;
   localparam int WDOG_TICKS     = WDOG_MS / TICK_MS;
   localparam int HALF_MIN_MS    = 30000;
   localparam int HALF_MIN_TICKS = HALF_MIN_MS / TICK_MS;
   localparam int REMAIN_W       = 17;

   // Register byte addresses
   localparam logic [7:0] ADDR_CFGA0   = 8'h00;
   localparam logic [7:0] ADDR_CFGB0   = 8'h08;
   localparam logic [7:0] ADDR_SWCTL0  = 8'h0C;
   localparam logic [7:0] ADDR_PSB     = 8'h0F;
   localparam logic [7:0] ADDR_STATB   = 8'h10;
   localparam logic [7:0] ADDR_TSTAT   = 8'h14;
   localparam logic [7:0] ADDR_CMD     = 8'h20;

   // Command codes written to the command register
   localparam logic [7:0] CMD_WRITE_CONFIG_A = 8'h01;
   localparam logic [7:0] CMD_CLEAR_STATUS   = 8'h02;

   // Field positions
   localparam int CODE_BYTE = 5;
   localparam int CODE_LSB  = 4;
   localparam int THERM_BIT = 0;
   localparam int VER_LSB   = 4;

   // Reset values
   localparam logic [7:0] CFGA_RST    = 8'h00;
   localparam logic [7:0] CFGB0_RST   = 8'h0F;
   localparam logic [7:0] CFGB1_RST   = 8'h00;
   localparam logic [7:0] GPIO_MASK   = 8'h0F;
   localparam logic [7:0] SWCTL_RST   = 8'h00;
   localparam logic [7:0] PSB_RST     = 8'h00;
   localparam logic [3:0] VERSION_DEF = 4'h5;  // Arbitrary value, carries no meaning

   // Bus request carrier
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } wdd_busreq_t;

   // Duration of each timeout code in half minutes
   function automatic logic [7:0] wdd_half_min(input logic [3:0] code);
      logic [7:0] h;
      h = 8'h00;
      case (code)
         4'h1: h = 8'h01;
         4'h2: h = 8'h02;
         4'h3: h = 8'h04;
         4'h4: h = 8'h06;
         4'h5: h = 8'h08;
         4'h6: h = 8'h0A;
         4'h7: h = 8'h14;
         4'h8: h = 8'h1E;
         4'h9: h = 8'h28;
         4'hA: h = 8'h3C;
         4'hB: h = 8'h50;
         4'hC: h = 8'h78;
         4'hD: h = 8'h96;
         4'hE: h = 8'hB4;
         4'hF: h = 8'hF0;
         default: h = 8'h00;
      endcase
      return h;
   endfunction

endpackage

// ---- hdl/wdd_watchdog_discharge_timer.sv ----
// Command watchdog, discharge timer, thermal shutdown and their configuration registers
//
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/1ps
module wdd_watchdog_discharge_timer #(
   parameter int TICK_CYCLES = wdd_pkg::TICK_CYCLES
) (
   // Clock and reset
   input  wire logic                ref_clk,
   input  wire logic                nrst,
   // Register and command port
   input  wire wdd_pkg::wdd_busreq_t busReq,
   output logic [7:0]               rdData_r,
   // Device pins and sensors
   input  wire logic                dischargeTimerEnablePin,
   input  wire logic                dieOverTemp,
   output logic                     watchdogOutPinO_r,
   output logic                     watchdogOutPinOe_r,
   output logic [17:0]              dischargeSw_r,
   output logic                     dischargeRunning_r
);
   import wdd_pkg::*;

   logic [24:0]         prescale_r;
   logic                tick_r;
   logic [4:0]          wdogTicks_r;
   logic                wdogExpire;
   logic                wdogExpired_r;
   logic [REMAIN_W-1:0] remain_r;
   logic                dischExpire;
   logic [7:0]          configAByte_r [6];
   logic [7:0]          stageA_r [6];
   logic [7:0]          configBByte_r [2];
   logic [7:0]          switchControlGroup_r [3];
   logic [7:0]          pwmSwitchB_r;
   logic                thermalShutdownFlag_r;
   logic                validCmd;
   logic                cmdWrite;
   logic                commitA;
   logic                clearStatus;
   logic                readStatB;
   logic                resetLow;
   logic                resetHigh;
   logic [3:0]          codeBucket;
   logic [3:0]          newCode;
   logic [REMAIN_W-1:0] loadTicks;
   logic [7:0]          rdNxt;

   // Command decode; every strobe arrives already checked upstream
   assign validCmd    = busReq.wr | busReq.rd;
   assign cmdWrite    = busReq.wr && (busReq.addr == ADDR_CMD);
   assign commitA     = cmdWrite && (busReq.wdata == CMD_WRITE_CONFIG_A);
   assign clearStatus = cmdWrite && (busReq.wdata == CMD_CLEAR_STATUS);
   assign readStatB   = busReq.rd && (busReq.addr == ADDR_STATB);

   // Shared time base for both timers
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         prescale_r <= 25'h0000000;
         tick_r     <= 1'b0;
      end else if (prescale_r == 25'(TICK_CYCLES - 1)) begin
         prescale_r <= 25'h0000000;
         tick_r     <= 1'b1;
      end else begin
         prescale_r <= prescale_r + 25'h0000001;
         tick_r     <= 1'b0;
      end
   end

   // Expires on the tick after a full two seconds of ticks, so always past two seconds
   assign wdogExpire = tick_r && !validCmd && !wdogExpired_r
                       && (wdogTicks_r == 5'(WDOG_TICKS));

   // Watchdog count, never disabled
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         wdogTicks_r   <= 5'h00;
         wdogExpired_r <= 1'b0;
      end else if (validCmd) begin
         wdogTicks_r   <= 5'h00;
         wdogExpired_r <= 1'b0;
      end else if (wdogExpire) begin
         wdogExpired_r <= 1'b1;
      end else if (tick_r && !wdogExpired_r) begin
         wdogTicks_r <= wdogTicks_r + 5'h01;
      end
   end

   // Open-drain pin: pulled low while alive, released on expiry
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         watchdogOutPinO_r  <= 1'b0;
         watchdogOutPinOe_r <= 1'b1;
      end else begin
         watchdogOutPinO_r  <= 1'b0;
         watchdogOutPinOe_r <= !(wdogExpired_r || wdogExpire);
      end
   end

   // Code about to be committed from the staged config A image
   assign newCode   = stageA_r[CODE_BYTE][CODE_LSB +: 4];
   assign loadTicks = REMAIN_W'(wdd_half_min(newCode)) * REMAIN_W'(HALF_MIN_TICKS);
   assign dischExpire = tick_r && dischargeRunning_r && (remain_r == REMAIN_W'(1));

   // Discharge countdown; ordinary commands leave it alone
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         remain_r           <= '0;
         dischargeRunning_r <= 1'b0;
      end else if (dieOverTemp) begin
         remain_r           <= '0;
         dischargeRunning_r <= 1'b0;
      end else if (commitA) begin
         remain_r           <= loadTicks;
         dischargeRunning_r <= dischargeTimerEnablePin && (newCode != 4'h0);
      end else if (dischExpire) begin
         remain_r           <= '0;
         dischargeRunning_r <= 1'b0;
      end else if (tick_r && dischargeRunning_r) begin
         remain_r <= remain_r - REMAIN_W'(1);
      end
   end

   // Which groups are cleared this cycle
   assign resetLow  = wdogExpire;
   assign resetHigh = dischExpire || (wdogExpire && !dischargeRunning_r);

   // Staging image of config A, filled by bus writes before the commit
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         for (int i = 0; i < 6; i++) stageA_r[i] <= CFGA_RST;
      end else if (busReq.wr && (busReq.addr >= ADDR_CFGA0) && (busReq.addr < ADDR_CFGA0 + 8'h06)) begin
         stageA_r[3'(busReq.addr - ADDR_CFGA0)] <= busReq.wdata;
      end
   end

   // Config A; a completed write lands even when an expiry hits the same cycle
   always_ff @(posedge ref_clk) begin
      if (!nrst || dieOverTemp) begin
         for (int i = 0; i < 6; i++) configAByte_r[i] <= CFGA_RST;
      end else if (commitA) begin
         for (int i = 0; i < 6; i++) configAByte_r[i] <= stageA_r[i];
      end else begin
         if (resetLow) begin
            for (int i = 0; i < 4; i++) configAByte_r[i] <= CFGA_RST;
         end
         if (resetHigh) begin
            configAByte_r[4] <= CFGA_RST;
            configAByte_r[5] <= CFGA_RST;
         end
      end
   end

   // Config B; GPIO bits follow the watchdog, the rest the discharge state
   always_ff @(posedge ref_clk) begin
      if (!nrst || dieOverTemp) begin
         configBByte_r[0] <= CFGB0_RST;
         configBByte_r[1] <= CFGB1_RST;
      end else if (busReq.wr && (busReq.addr[7:1] == ADDR_CFGB0[7:1])) begin
         configBByte_r[busReq.addr[0]] <= busReq.wdata;
      end else begin
         if (resetLow) begin
            configBByte_r[0] <= (configBByte_r[0] & ~GPIO_MASK) | (CFGB0_RST & GPIO_MASK);
         end
         if (resetHigh) begin
            configBByte_r[0] <= (CFGB0_RST & ~GPIO_MASK)
                                | ((resetLow ? CFGB0_RST : configBByte_r[0]) & GPIO_MASK);
            configBByte_r[1] <= CFGB1_RST;
         end
      end
   end

   // Switch control group and its bits in the pulse-width group
   always_ff @(posedge ref_clk) begin
      if (!nrst || dieOverTemp || resetHigh) begin
         for (int i = 0; i < 3; i++) switchControlGroup_r[i] <= SWCTL_RST;
         pwmSwitchB_r <= PSB_RST;
      end else if (busReq.wr && (busReq.addr >= ADDR_SWCTL0) && (busReq.addr < ADDR_PSB)) begin
         switchControlGroup_r[2'(busReq.addr - ADDR_SWCTL0)] <= busReq.wdata;
      end else if (busReq.wr && (busReq.addr == ADDR_PSB)) begin
         pwmSwitchB_r <= busReq.wdata;
      end
   end

   // Thermal flag; a set in the same cycle as a status read wins
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         thermalShutdownFlag_r <= 1'b0;
      end else if (dieOverTemp || clearStatus) begin
         thermalShutdownFlag_r <= 1'b1;
      end else if (readStatB) begin
         thermalShutdownFlag_r <= 1'b0;
      end
   end

   // Discharge switches follow the cell discharge bits of config A and B
   always_ff @(posedge ref_clk) begin
      if (!nrst || dieOverTemp) begin
         dischargeSw_r <= 18'h00000;
      end else begin
         dischargeSw_r <= {configBByte_r[1][1:0], configBByte_r[0][7:4],
                           configAByte_r[5][3:0], configAByte_r[4]};
      end
   end

   // Remaining time as the smallest code whose duration covers it
   always_comb begin
      codeBucket = 4'h0;
      if (dischargeRunning_r) begin
         for (int c = 15; c >= 1; c--) begin
            if (remain_r <= REMAIN_W'(wdd_half_min(4'(c))) * REMAIN_W'(HALF_MIN_TICKS)) begin
               codeBucket = 4'(c);
            end
         end
      end
   end

   // Read mux; unmapped addresses read as zero
   always_comb begin
      rdNxt = 8'h00;
      if (busReq.addr < ADDR_CFGA0 + 8'h06) begin
         rdNxt = configAByte_r[3'(busReq.addr - ADDR_CFGA0)];
         if (busReq.addr == ADDR_CFGA0 + 8'(CODE_BYTE)) begin
            rdNxt[CODE_LSB +: 4] = codeBucket;
         end
      end else if (busReq.addr[7:1] == ADDR_CFGB0[7:1]) begin
         rdNxt = configBByte_r[busReq.addr[0]];
      end else if ((busReq.addr >= ADDR_SWCTL0) && (busReq.addr < ADDR_PSB)) begin
         rdNxt = switchControlGroup_r[2'(busReq.addr - ADDR_SWCTL0)];
      end else if (busReq.addr == ADDR_PSB) begin
         rdNxt = pwmSwitchB_r;
      end else if (busReq.addr == ADDR_STATB) begin
         rdNxt[VER_LSB +: 4]  = VERSION_DEF;
         rdNxt[THERM_BIT]     = thermalShutdownFlag_r;
      end else if (busReq.addr == ADDR_TSTAT) begin
         rdNxt = {6'h00, dischargeRunning_r, wdogExpired_r};
      end
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         rdData_r <= 8'h00;
      end else begin
         rdData_r <= busReq.rd ? rdNxt : 8'h00;
      end
   end

endmodule // wdd_watchdog_discharge_timer

// ---- verification/wdd_chk.sv ----
// Port checker for the watchdog and discharge timer
`timescale 1ns/1ps
module wdd_chk #(
   parameter int TICK_CYCLES = 10
) (
   // Clock and reset
   input wire logic                 ref_clk,
   input wire logic                 nrst,
   // Register and command port
   input wire wdd_pkg::wdd_busreq_t busReq,
   input wire logic [7:0]           rdData_r,
   // Device pins and sensors
   input wire logic                 dischargeTimerEnablePin,
   input wire logic                 dieOverTemp,
   input wire logic                 watchdogOutPinO_r,
   input wire logic                 watchdogOutPinOe_r,
   input wire logic [17:0]          dischargeSw_r,
   input wire logic                 dischargeRunning_r
);
   import wdd_pkg::*;
   // Tick phase is unknown, so allow one tick plus pipeline slack
   localparam int WD_MIN = 20 * TICK_CYCLES;
   localparam int WD_MAX = 21 * TICK_CYCLES + 4;
   logic cmd;
   logic statRd;
   int   idle_r;
   assign cmd    = busReq.wr | busReq.rd;
   assign statRd = busReq.rd && busReq.addr == ADDR_STATB;
   // Cycles since the last command
   always_ff @(posedge ref_clk) begin
      if (!nrst || cmd) begin
         idle_r <= 0;
      end else begin
         idle_r <= idle_r + 1;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   a_pin_data_low: assert property (watchdogOutPinO_r == 1'b0)
      else $error("watchdog pin data not low");
   a_wdog_not_early: assert property ($fell(watchdogOutPinOe_r) |-> idle_r >= WD_MIN)
      else $error("watchdog expired early");
   a_wdog_not_late: assert property (idle_r > WD_MAX |-> !watchdogOutPinOe_r)
      else $error("watchdog expired late");
   a_cmd_restores: assert property (cmd |-> ##[1:2] watchdogOutPinOe_r)
      else $error("command did not restart watchdog");
   a_temp_clears: assert property (dieOverTemp [*3] |-> dischargeSw_r == 18'h0 && !dischargeRunning_r)
      else $error("switches on during over temperature");
   a_stat_version: assert property (statRd |=> rdData_r[7:4] == VERSION_DEF)
      else $error("version field wrong");
   a_idle_bucket: assert property (busReq.rd && busReq.addr == 8'h05 && !dischargeRunning_r |=> rdData_r[7:4] == 4'h0)
      else $error("bucket not zero while idle");
   a_run_needs_pin: assert property ($rose(dischargeRunning_r) |-> $past(dischargeTimerEnablePin))
      else $error("timer ran with enable pin low");
   a_therm_sets: assert property ($fell(dieOverTemp) && $past(nrst) && statRd |=> rdData_r[THERM_BIT])
      else $error("thermal flag not set");
   a_clear_sets: assert property (busReq.wr && busReq.addr == ADDR_CMD && busReq.wdata == CMD_CLEAR_STATUS
      ##1 !statRd ##1 statRd |=> rdData_r[THERM_BIT])
      else $error("clear status did not set flag");
   a_read_clears: assert property (statRd && !dieOverTemp ##1 !busReq.wr && !dieOverTemp
      ##1 statRd && !dieOverTemp |=> !rdData_r[THERM_BIT])
      else $error("status read did not clear flag");
   c_wdog: cover property ($fell(watchdogOutPinOe_r));
   c_dexp: cover property ($fell(dischargeRunning_r));
   c_temp: cover property (dieOverTemp [*3]);
endmodule // wdd_chk

bind wdd_watchdog_discharge_timer wdd_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
   .ref_clk(ref_clk), .nrst(nrst), .busReq(busReq), .rdData_r(rdData_r),
   .dischargeTimerEnablePin(dischargeTimerEnablePin), .dieOverTemp(dieOverTemp),
   .watchdogOutPinO_r(watchdogOutPinO_r), .watchdogOutPinOe_r(watchdogOutPinOe_r),
   .dischargeSw_r(dischargeSw_r), .dischargeRunning_r(dischargeRunning_r));

// ---- verification/wdd_host.sv ----
// Host model driving the register and command port
`timescale 1ns/1ps
module wdd_host (
   // Clock
   input  wire logic           ref_clk,
   // Register and command port
   output wdd_pkg::wdd_busreq_t busReq,
   input  wire logic [7:0]     rdData_r
);
   import wdd_pkg::*;
   initial busReq = '0;
   // Idle cycle after each strobe so two tasks never drive one edge
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      busReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
      @(posedge ref_clk);
      busReq <= '0;
      @(posedge ref_clk);
   endtask
   // Data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      busReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge ref_clk);
      busReq <= '0;
      @(posedge ref_clk);
      v = rdData_r; // Whole byte kept, suspect near an expiry
   endtask
endmodule // wdd_host

// ---- verification/testbench.sv ----
// Self-checking testbench for the watchdog and discharge timer
`timescale 1ns/1ps
module testbench;
   import wdd_pkg::*;
   localparam int TC = 10;
   logic        ref_clk = 1'b0;
   logic        nrst = 1'b0;
   logic        dischargeTimerEnablePin = 1'b0;
   logic        dieOverTemp = 1'b0;
   wdd_busreq_t busReq;
   logic [7:0]  rdData_r;
   logic        watchdogOutPinO_r;
   logic        watchdogOutPinOe_r;
   logic [17:0] dischargeSw_r;
   logic        dischargeRunning_r;
   logic [7:0]  d;
   int          fails = 0;
   int          n_checks = 0;
   logic        wdPin;
   always #2.5 ref_clk = ~ref_clk;
   // External pull-up lifts the pin once the device lets go
   assign wdPin = watchdogOutPinOe_r ? watchdogOutPinO_r : 1'b1;
   wdd_watchdog_discharge_timer #(.TICK_CYCLES(TC)) DUT (.ref_clk(ref_clk), .nrst(nrst), .busReq(busReq),
      .rdData_r(rdData_r), .dischargeTimerEnablePin(dischargeTimerEnablePin), .dieOverTemp(dieOverTemp),
      .watchdogOutPinO_r(watchdogOutPinO_r), .watchdogOutPinOe_r(watchdogOutPinOe_r),
      .dischargeSw_r(dischargeSw_r), .dischargeRunning_r(dischargeRunning_r));
   wdd_host host (.ref_clk(ref_clk), .busReq(busReq), .rdData_r(rdData_r));
   task automatic chk(input string name, input logic [17:0] exp, input logic [17:0] got);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask
   // Read one byte and compare it
   task automatic rdc(input string name, input logic [7:0] a, input logic [7:0] exp);
      host.rd(a, d);
      chk(name, 18'(exp), 18'(d));
   endtask
   // Stage config A with all ones except byte 5, then commit
   task automatic cfg(input logic [7:0] a5);
      for (int i = 0; i < 5; i++) host.wr(ADDR_CFGA0 + 8'(i), 8'hFF);
      host.wr(8'h05, a5);
      host.wr(ADDR_SWCTL0, 8'hFF);
      host.wr(ADDR_CMD, CMD_WRITE_CONFIG_A);
      repeat (2) @(posedge ref_clk);
   endtask
   task automatic t_reset();
      rdc("statB", ADDR_STATB, {VERSION_DEF, 4'h0});
      rdc("unmapped", 8'h30, 8'h00);
      $display("test reset done");
   endtask
   task automatic t_wdog();
      host.wr(ADDR_CFGB0, 8'hF0);
      cfg(8'hFF);
      chk("running", 18'h0, 18'(dischargeRunning_r));
      repeat (25 * TC) @(posedge ref_clk);
      chk("oe", 18'h0, 18'(watchdogOutPinOe_r));
      chk("pin", 18'h1, 18'(wdPin));
      rdc("a0", ADDR_CFGA0, 8'h00);
      // Pin enable comes back one edge after the read data
      @(posedge ref_clk);
      chk("oe", 18'h1, 18'(watchdogOutPinOe_r));
      rdc("a4", 8'h04, 8'h00);
      rdc("swctl", ADDR_SWCTL0, 8'h00);
      rdc("b0", ADDR_CFGB0, CFGB0_RST);
      $display("test watchdog done");
   endtask
   task automatic t_dtimer();
      dischargeTimerEnablePin <= 1'b1;
      host.wr(ADDR_CFGB0, 8'hF0);
      cfg(8'h1F);
      chk("running", 18'h1, 18'(dischargeRunning_r));
      rdc("bucket", 8'h05, 8'h1F);
      repeat (25 * TC) @(posedge ref_clk);
      chk("oe", 18'h0, 18'(watchdogOutPinOe_r));
      chk("sw", 18'h0FFFF, dischargeSw_r);
      rdc("a0", ADDR_CFGA0, 8'h00);
      rdc("b0", ADDR_CFGB0, 8'hFF);
      rdc("a4", 8'h04, 8'hFF);
      for (int i = 0; i < 40 && dischargeRunning_r === 1'b1; i++) begin
         repeat (90) @(posedge ref_clk);
         host.rd(ADDR_TSTAT, d);
      end
      @(posedge ref_clk);
      chk("running", 18'h0, 18'(dischargeRunning_r));
      chk("sw", 18'h0, dischargeSw_r);
      rdc("a4", 8'h04, 8'h00);
      rdc("bucket", 8'h05, 8'h00);
      rdc("b0", ADDR_CFGB0, CFGB0_RST);
      rdc("swctl", ADDR_SWCTL0, 8'h00);
      cfg(8'h0F);
      chk("running", 18'h0, 18'(dischargeRunning_r));
      dischargeTimerEnablePin <= 1'b0;
      $display("test discharge done");
   endtask
   task automatic t_therm();
      cfg(8'h0F);
      dieOverTemp <= 1'b1;
      repeat (3) @(posedge ref_clk);
      dieOverTemp <= 1'b0;
      rdc("flag", ADDR_STATB, {VERSION_DEF, 4'h1});
      rdc("flag", ADDR_STATB, {VERSION_DEF, 4'h0});
      chk("sw", 18'h0, dischargeSw_r);
      rdc("a4", 8'h04, 8'h00);
      host.wr(ADDR_SWCTL0, 8'hAA);
      host.wr(ADDR_CMD, CMD_CLEAR_STATUS);
      rdc("flag", ADDR_STATB, {VERSION_DEF, 4'h1});
      rdc("swctl", ADDR_SWCTL0, 8'hAA);
      $display("test thermal done");
   endtask
   task automatic results();
      $display("checks %0d, mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Tests need about 3400 cycles
   initial begin
      repeat (20000) @(posedge ref_clk);
      fails++;
      results();
   end
   initial begin
      repeat (4) @(posedge ref_clk);
      nrst <= 1'b1;
      t_reset();
      t_wdog();
      t_dtimer();
      t_therm();
      results();
   end
endmodule // testbench
